// [rtl/srs_regs.svh]
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// Clock and time base
`define SRS_CLK_HZ 250000000
`define SRS_TB_HZ 420000
// Blanking interval in microseconds
`define SRS_BLANK_US 2380
// Burst: sixteen pulses at 49.4 kHz, frequency in Hz tenths
`define SRS_BURST_PULSES 16
`define SRS_BURST_DHZ 494000
// Time to maximum gain in milliseconds
`define SRS_GAIN_MAX_MS 38
// Number of gain steps above the first
`define SRS_GAIN_STEPS 15
// Time base ticks per transducer half period (420k / 49.4k / 2, rounded)
`define SRS_HALF_TICKS 4
// Time base ticks of blanking (2.38 ms * 420 kHz, rounded up)
`define SRS_BLANK_TICKS 1000
// Time base ticks to maximum gain (38 ms * 420 kHz, rounded down)
`define SRS_GAIN_TICKS 15960
// Half-cycle divide of the system clock for the 420 kHz time base
`define SRS_TB_HALF ((`SRS_CLK_HZ / `SRS_TB_HZ) / 2)

`endif

// [rtl/srs_pkg.sv]
package srs_pkg;

  // Sequencer phases of one ranging cycle
  typedef enum logic [1:0] {
    IDLE,
    BURST,
    LISTEN
  } srs_state_type;

endpackage : srs_pkg

// [rtl/srs_sequencer.sv]
`timescale 1ns/100ps
`include "srs_regs.svh"

module srs_sequencer #(
  parameter int BLANK_TICKS = `SRS_BLANK_TICKS,
  parameter int GAIN_TICKS = `SRS_GAIN_TICKS,
  parameter int TB_HALF = `SRS_TB_HALF,
  parameter int GAIN_W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host control
  input wire logic trigger,
  input wire logic blank_override,
  input wire logic echo_rearm,
  // Receiver
  input wire logic receive_input,
  output logic [GAIN_W-1:0] gainStep,
  // Host results
  output logic returnDetected,
  output logic timebase_out,
  // Transducer
  output logic transducer_drive
);

  // Equal gain steps; any remainder ticks are dropped
  localparam int GAIN_STEP_TICKS = GAIN_TICKS / `SRS_GAIN_STEPS;

  // Cycle phase
  srs_pkg::srs_state_type state_reg, state_next;

  // Time base divider and tick strobe
  logic [15:0] tbDiv_reg, tbDiv_next;
  logic tbClk_reg, tbClk_next;
  logic tick;

  // Trigger edge detect; reset high so a trigger held
  // through reset must fall before it starts a cycle
  logic trigPrev_reg, trigPrev_next;
  logic trigRise;

  // Blanking timer, saturating so it never wraps back
  logic [15:0] cycTick_reg, cycTick_next;
  logic blank_reg, blank_next;

  // Gain schedule: ticks within a step, and the step
  logic [15:0] stepTick_reg, stepTick_next;
  logic [GAIN_W-1:0] gain_reg, gain_next;

  // Burst: ticks within a half period, half periods sent
  logic [2:0] half_reg, half_next;
  logic [5:0] edges_reg, edges_next;
  logic drive_reg, drive_next;

  // Return latch
  logic echo_reg, echo_next;

  // time base divider
  // Free-running, also exported; one tick per full period
  always_comb begin
    tbDiv_next = tbDiv_reg + 16'h0001;
    tbClk_next = tbClk_reg;
    tick = 1'b0;
    if (tbDiv_reg == 16'(TB_HALF - 1)) begin
      tbDiv_next = 16'h0000;
      tbClk_next = ~tbClk_reg;
      tick = ~tbClk_reg;
    end
  end

  assign trigRise = trigger & ~trigPrev_reg;

  // Cycle sequencer: burst, blanking, gain, return latch
  always_comb begin
    state_next = state_reg;
    trigPrev_next = trigger;
    cycTick_next = cycTick_reg;
    stepTick_next = stepTick_reg;
    gain_next = gain_reg;
    half_next = half_reg;
    edges_next = edges_reg;
    drive_next = drive_reg;
    blank_next = blank_reg;
    echo_next = echo_reg;
    case (state_reg)
      srs_pkg::IDLE: begin
        drive_next = 1'b0;
        blank_next = 1'b1;
      end
      srs_pkg::BURST: begin
        // sixteen-pulse burst
        // Drive starts high on the rise, then 31 toggles
        if (tick) begin
          if (half_reg == 3'(`SRS_HALF_TICKS - 1)) begin
            half_next = 3'h0;
            if (edges_reg == 6'(2 * `SRS_BURST_PULSES - 1)) begin
              drive_next = 1'b0;
              state_next = srs_pkg::LISTEN;
            end else begin
              drive_next = ~drive_reg;
              edges_next = edges_reg + 6'h01;
            end
          end else begin
            half_next = half_reg + 3'h1;
          end
        end
      end
      srs_pkg::LISTEN: begin
        drive_next = 1'b0;
      end
      default: state_next = srs_pkg::IDLE;
    endcase
    if (state_reg != srs_pkg::IDLE && tick) begin
      if (cycTick_reg != 16'hffff) begin
        cycTick_next = cycTick_reg + 16'h0001;
      end
      if (cycTick_reg == 16'(BLANK_TICKS - 1)) begin
        blank_next = 1'b0;
      end
      if (gain_reg != GAIN_W'(`SRS_GAIN_STEPS)) begin
        if (stepTick_reg == 16'(GAIN_STEP_TICKS - 1)) begin
          stepTick_next = 16'h0000;
          gain_next = gain_reg + 1'b1;
        end else begin
          stepTick_next = stepTick_reg + 16'h0001;
        end
      end
    end
    // override ends blanking
    // Ignored in idle so it cannot pre-clear blanking
    if (state_reg != srs_pkg::IDLE && blank_override) begin
      blank_next = 1'b0;
    end
    if (state_reg != srs_pkg::IDLE && !blank_reg && !echo_rearm &&
        receive_input) begin
      echo_next = 1'b1;
    end
    // rearm clears, blocks detection
    // Placed after detection so the clear wins
    if (echo_rearm) begin
      echo_next = 1'b0;
    end
    if (!trigger) begin
      state_next = srs_pkg::IDLE;
      echo_next = 1'b0;
      drive_next = 1'b0;
    end
    // each rising trigger starts fresh
    // Placed last so a restart overrides all else
    if (trigRise) begin
      state_next = srs_pkg::BURST;
      cycTick_next = 16'h0000;
      stepTick_next = 16'h0000;
      gain_next = '0;
      half_next = 3'h0;
      edges_next = 6'h00;
      drive_next = 1'b1;
      blank_next = 1'b1;
      echo_next = 1'b0;
    end
  end

  // State registers
  // Synchronous reset puts every group but the trigger edge detect at its idle value
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= srs_pkg::IDLE;
      tbDiv_reg <= 16'h0000;
      tbClk_reg <= 1'b0;
      trigPrev_reg <= 1'b1;
      cycTick_reg <= 16'h0000;
      stepTick_reg <= 16'h0000;
      gain_reg <= '0;
      half_reg <= 3'h0;
      edges_reg <= 6'h00;
      drive_reg <= 1'b0;
      blank_reg <= 1'b1;
      echo_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tbDiv_reg <= tbDiv_next;
      tbClk_reg <= tbClk_next;
      trigPrev_reg <= trigPrev_next;
      cycTick_reg <= cycTick_next;
      stepTick_reg <= stepTick_next;
      gain_reg <= gain_next;
      half_reg <= half_next;
      edges_reg <= edges_next;
      drive_reg <= drive_next;
      blank_reg <= blank_next;
      echo_reg <= echo_next;
    end
  end

  // Registered outputs
  assign gainStep = gain_reg;
  assign returnDetected = echo_reg;
  assign timebase_out = tbClk_reg;
  assign transducer_drive = drive_reg;

endmodule : srs_sequencer

// [verif/srs_sequencer_sva.sv]
`timescale 1ns/100ps
module srs_sequencer_sva #(parameter int GAIN_W = 4) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Watched ports
  input wire logic trigger,
  input wire logic blank_override,
  input wire logic echo_rearm,
  input wire logic receive_input,
  input wire logic [GAIN_W-1:0] gainStep,
  input wire logic returnDetected,
  input wire logic transducer_drive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Latch and its clearing
  property p_clr; !trigger || echo_rearm |=> !returnDetected; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_hold; returnDetected && trigger && !echo_rearm
    |=> returnDetected; endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_set; $rose(returnDetected) |-> $past(receive_input)
    && !$past(echo_rearm); endproperty
  a_set: assert property (p_set) else $error("bad set");
  // Burst and blanking after a rise
  property p_burst; $rose(trigger) && $past(resetn)
    |=> transducer_drive; endproperty
  a_burst: assert property (p_burst) else $error("no burst");
  // Cycles since a trigger rise with override low; 15 means idle
  logic [3:0] sinceRise;
  always_ff @(posedge clk_sys) begin
    if (!resetn || !trigger || blank_override) begin
      sinceRise <= 4'hf;
    end else if ($rose(trigger)) begin
      sinceRise <= 4'h0;
    end else if (sinceRise != 4'hf) begin
      sinceRise <= sinceRise + 4'h1;
    end
  end
  property p_blank; sinceRise < 4'h9 |-> !returnDetected; endproperty
  a_blank: assert property (p_blank) else $error("not blanked");
  property p_ovr; (trigger && blank_override && !echo_rearm) [*3]
    ##0 receive_input |=> returnDetected; endproperty
  a_ovr: assert property (p_ovr) else $error("override");
  // Gain steps
  property p_gain; $past(trigger) && trigger |=> gainStep
    == $past(gainStep) || gainStep == $past(gainStep) + 1'b1; endproperty
  a_gain: assert property (p_gain) else $error("gain step");
  property p_max; $past(trigger) && trigger && gainStep == '1
    |=> gainStep == '1; endproperty
  a_max: assert property (p_max) else $error("gain max");
endmodule : srs_sequencer_sva

// [verif/srs_host_model.sv]
`timescale 1ns/100ps
module srs_host_model (
  // Clock
  input wire logic clk_sys,
  // Host control
  output logic trigger = 1'h0,
  output logic blank_override = 1'h0,
  output logic echo_rearm = 1'h0
);
  task automatic fire(input logic ovr);
    @(negedge clk_sys) trigger = 1'h0;
    blank_override = ovr;
    @(negedge clk_sys) trigger = 1'h1;
  endtask : fire
  task automatic rearm();
    @(negedge clk_sys) echo_rearm = 1'h1;
    repeat (8) @(negedge clk_sys);
    echo_rearm = 1'h0;
  endtask : rearm
endmodule : srs_host_model

// [verif/srs_sequencer_tb_top.sv]
`timescale 1ns/100ps
module srs_sequencer_tb_top;
  logic clk_sys = 1'h0, resetn = 1'h0, receive_input = 1'h0, rdPrev;
  logic trigger, blank_override, echo_rearm, returnDetected;
  logic timebase_out, transducer_drive;
  logic tbPrev, drPrev, trgPrev;
  int pulses = 0, tbLast = 0;
  logic [3:0] gainStep;
  logic [16:0] lfsr = 17'h1511f;
  int errors = 0, n_tests = 0, tnow = 0;
  int expq[$];
  // Clock
  always #2 clk_sys = ~clk_sys;
  srs_sequencer #(.BLANK_TICKS(10), .GAIN_TICKS(150), .TB_HALF(2)) dut (
    .clk_sys, .resetn, .trigger, .blank_override, .echo_rearm,
    .receive_input, .gainStep, .returnDetected, .timebase_out,
    .transducer_drive);
  srs_host_model host (.clk_sys, .trigger, .blank_override, .echo_rearm);
  task automatic check(string what, logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %0d seen %0d", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [16:0] nxt(logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : nxt
  // Cycle count and echo timing against oldest note
  always @(posedge clk_sys) begin
    tnow <= tnow + 1;
    rdPrev <= returnDetected;
    tbPrev <= timebase_out;
    drPrev <= transducer_drive;
    trgPrev <= trigger;
    // Burst pulses since the latest trigger rise
    if (trigger && !trgPrev) begin
      pulses <= 0;
    end else if (transducer_drive && !drPrev) begin
      pulses <= pulses + 1;
    end
    // Time base period, two half periods of TB_HALF clocks
    if (timebase_out && !tbPrev) begin
      if (tbLast > 0) begin
        check("tb period", tnow - tbLast, 4);
      end
      tbLast <= tnow;
    end
    if (returnDetected && !rdPrev) begin
      check("echo time", tnow, expq.pop_front());
    end
  end
  // Ranging cycle with ringing pulse when override is low, echo, rearm, second echo
  task automatic echo(input logic ovr, input int k);
    host.fire(ovr);
    if (!ovr) begin
      repeat (2) @(negedge clk_sys);
      receive_input = 1'h1;
      repeat (3) @(negedge clk_sys);
      receive_input = 1'h0;
    end
    repeat (k) @(negedge clk_sys);
    receive_input = 1'h1;
    expq.push_back(tnow + 1);
    repeat (3) @(negedge clk_sys);
    host.rearm();
    expq.push_back(tnow + 1);
    repeat (3) @(negedge clk_sys);
    receive_input = 1'h0;
    $display("cycle done override %0b", ovr);
  endtask : echo
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      echo(i[0], i[0] ? 3 : 64 + lfsr[5:0]);
    end
    repeat (800) @(negedge clk_sys);
    check("gain", gainStep, 4'hf);
    check("pulses", pulses, 16);
    check("notes", expq.size(), 0);
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end
endmodule : srs_sequencer_tb_top
bind srs_sequencer srs_sequencer_sva #(.GAIN_W(GAIN_W)) chk (.clk_sys,
  .resetn, .trigger, .blank_override, .echo_rearm, .receive_input,
  .gainStep, .returnDetected, .transducer_drive);
